/* File: verilog/sccs_defines.svh */
// constants for the switching clock source select block
//
// Behaviour
// - With the mode strap low, a search for an external clock on the sync pin starts every time enable is asserted.
// - Once an external clock is found, the internal oscillator phase is realigned to each of its rising edges.
// - If the external clock is lost, the block moves to its internal oscillator at a frequency near the last one seen.
// - With the mode strap open, the block checks for an external clock after enable and follows it if present.
// - In auto-detect with no clock, the sync strap sets 200 kHz for low, 400 kHz for open, 1 MHz for high.
// - The sync and mode straps are sampled only during start-up and ignored until the next power cycle.
// - A frequency-set resistor on the sync pin selects one of nineteen frequencies from 200 kHz to 1333 kHz.
// - A frequency written over the management bus is realised as 8 MHz divided by a whole N from 6 to 40.
// - A written frequency that is not an exact divider result is replaced by the nearest allowed frequency.
// - On a shared sync line one device is strapped as clock output and every other one as auto-detect.
// - The frequency read back may differ slightly from the nominal value because of quantisation.
// - With the mode strap high, the block runs its internal 400 kHz oscillator, drives it out and never searches.
`ifndef SCCS_DEFINES_SVH
`define SCCS_DEFINES_SVH

`define SCCS_SYS_CLK_KHZ    20000
`define SCCS_OSC_KHZ        8000
`define SCCS_EXT_MIN_KHZ    200
`define SCCS_EXT_MAX_KHZ    1400
`define SCCS_FREQ_MIN_KHZ   200
`define SCCS_FREQ_MAX_KHZ   1333
`define SCCS_N_MIN          6
`define SCCS_N_MAX          40
`define SCCS_N_LOW          40
`define SCCS_N_OPEN         20
`define SCCS_N_HIGH         8
`define SCCS_N_RESET        20
// loss of clock: two periods of the slowest legal input
`define SCCS_LOSS_CYC       ((2 * `SCCS_SYS_CLK_KHZ) / `SCCS_EXT_MIN_KHZ)
`define SCCS_STRAP_SETTLE   4

`endif

/* File: verilog/sccs_pkg.sv */
// types for the switching clock source select block
`default_nettype none
package sccs_pkg;

    typedef enum logic [1:0] {
        SCCS_LVL_LOW  = 2'h0,
        SCCS_LVL_OPEN = 2'h1,
        SCCS_LVL_HIGH = 2'h2,
        SCCS_LVL_RES  = 2'h3
    } sccs_level_type;

    typedef enum logic [2:0] {
        SCCS_ST_STARTUP  = 3'h0,
        SCCS_ST_READY    = 3'h1,
        SCCS_ST_DETECT   = 3'h2,
        SCCS_ST_LOCKED   = 3'h3,
        SCCS_ST_HOLD     = 3'h4,
        SCCS_ST_INTERNAL = 3'h5,
        SCCS_ST_DRIVE    = 3'h6
    } sccs_state_type;

endpackage
`default_nettype wire

/* File: verilog/sccs_edge_meter.sv */
// period meter and loss detector for the incoming sync clock
`timescale 1ns/1ns
`default_nettype none
`include "sccs_defines.svh"
module sccs_edge_meter #(
    parameter int CNT_W = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             ce_in,
    input  wire logic             restart_in,
    input  wire logic             rise_in,
    output logic [CNT_W-1:0]      period_out,
    output logic                  period_valid_out,
    output logic                  timeout_out
);
    localparam logic [CNT_W-1:0] LOSS = CNT_W'(`SCCS_LOSS_CYC);

    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] per_q, per_d;
    logic             seen_q, seen_d;
    logic             val_q, val_d;
    logic             tmo_q, tmo_d;

    always_comb begin
        cnt_d  = (cnt_q == LOSS) ? cnt_q : cnt_q + CNT_W'(1);
        per_d  = per_q;
        seen_d = seen_q;
        val_d  = 1'b0;
        tmo_d  = (cnt_q == LOSS);
        if (restart_in) begin
            cnt_d  = '0;
            seen_d = 1'b0;
            tmo_d  = 1'b0;
        end else if (rise_in) begin
            cnt_d  = '0;
            seen_d = 1'b1;
            tmo_d  = 1'b0;
            if (seen_q) begin
                per_d = cnt_q + CNT_W'(1);
                val_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q  <= '0;
            per_q  <= '0;
            seen_q <= 1'b0;
            val_q  <= 1'b0;
            tmo_q  <= 1'b0;
        end else if (ce_in) begin
            cnt_q  <= cnt_d;
            per_q  <= per_d;
            seen_q <= seen_d;
            val_q  <= val_d;
            tmo_q  <= tmo_d;
        end
    end

    assign period_out       = per_q;
    assign period_valid_out = val_q;
    assign timeout_out      = tmo_q;

endmodule // sccs_edge_meter
`default_nettype wire

/* File: verilog/sccs_top.sv */
// switching clock source select: strap capture, sync detect, lock, holdover, frequency set
`timescale 1ns/1ns
`default_nettype none
`include "sccs_defines.svh"
module sccs_top (
    input  wire logic                    clk_in,
    input  wire logic                    rst_b_in,
    input  wire logic                    ce_in,
    input  wire logic                    en_in,
    input  wire sccs_pkg::sccs_level_type mode_strap_in,
    input  wire sccs_pkg::sccs_level_type sync_strap_in,
    input  wire logic [4:0]              freq_set_resistor_in,
    input  wire logic                    sync_in,
    input  wire logic                    freq_wr_in,
    input  wire logic [10:0]             freq_khz_in,
    output logic                         sw_clk_out,
    output logic                         sync_out,
    output logic                         sync_oe_out,
    output logic                         ext_lock_out,
    output logic                         holdover_out,
    output logic [5:0]                   fsw_div_out
);
    import sccs_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [5:0] clamp_n(input logic [13:0] n);
        if (n < 14'(`SCCS_N_MIN))
            clamp_n = 6'(`SCCS_N_MIN);
        else if (n > 14'(`SCCS_N_MAX))
            clamp_n = 6'(`SCCS_N_MAX);
        else
            clamp_n = n[5:0];
    endfunction

    // nearest 8 MHz / N to a requested frequency in kHz
    function automatic logic [5:0] khz_to_n(input logic [10:0] f);
        logic [13:0] n_lo;
        logic [13:0] f_hi;
        logic [13:0] f_lo;
        logic [13:0] fw;
        fw = {3'h0, f};
        if (fw <= 14'(`SCCS_FREQ_MIN_KHZ)) begin
            khz_to_n = 6'(`SCCS_N_MAX);
        end else if (fw >= 14'(`SCCS_FREQ_MAX_KHZ)) begin
            khz_to_n = 6'(`SCCS_N_MIN);
        end else begin
            n_lo = 14'(`SCCS_OSC_KHZ) / fw;
            f_hi = 14'(`SCCS_OSC_KHZ) / n_lo;
            f_lo = 14'(`SCCS_OSC_KHZ) / (n_lo + 14'h1);
            if ((f_hi - fw) <= (fw - f_lo))
                khz_to_n = clamp_n(n_lo);
            else
                khz_to_n = clamp_n(n_lo + 14'h1);
        end
    endfunction

    // measured input period in system cycles to the nearest divider
    // the product needs 21 bits for the longest period, so keep it wide until after the divide
    function automatic logic [5:0] period_to_n(input logic [7:0] p);
        logic [23:0] num;
        num = 24'(`SCCS_OSC_KHZ) * {16'h0000, p};
        period_to_n = clamp_n(14'((num + 24'(`SCCS_SYS_CLK_KHZ / 2)) / 24'(`SCCS_SYS_CLK_KHZ)));
    endfunction

    // nineteen resistor positions, each an exact 8 MHz / N setting
    function automatic logic [5:0] res_to_n(input logic [4:0] idx);
        unique case (idx)
            5'h00: res_to_n = 6'h28;
            5'h01: res_to_n = 6'h24;
            5'h02: res_to_n = 6'h21;
            5'h03: res_to_n = 6'h1e;
            5'h04: res_to_n = 6'h1b;
            5'h05: res_to_n = 6'h19;
            5'h06: res_to_n = 6'h16;
            5'h07: res_to_n = 6'h14;
            5'h08: res_to_n = 6'h13;
            5'h09: res_to_n = 6'h11;
            5'h0a: res_to_n = 6'h0f;
            5'h0b: res_to_n = 6'h0e;
            5'h0c: res_to_n = 6'h0d;
            5'h0d: res_to_n = 6'h0b;
            5'h0e: res_to_n = 6'h0a;
            5'h0f: res_to_n = 6'h09;
            5'h10: res_to_n = 6'h08;
            5'h11: res_to_n = 6'h07;
            5'h12: res_to_n = 6'h06;
            default: res_to_n = 6'(`SCCS_N_MAX);
        endcase
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] mode_m_q, mode_s_q, strap_m_q, strap_s_q;
    logic [4:0] res_m_q, res_s_q;
    logic       en_m_q, en_s_q, sync_m_q, sync_s_q, sync_p_q;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_m_q  <= 2'h0;
            mode_s_q  <= 2'h0;
            strap_m_q <= 2'h0;
            strap_s_q <= 2'h0;
            res_m_q   <= 5'h00;
            res_s_q   <= 5'h00;
            en_m_q    <= 1'b0;
            en_s_q    <= 1'b0;
            sync_m_q  <= 1'b0;
            sync_s_q  <= 1'b0;
            sync_p_q  <= 1'b0;
        end else if (ce_in) begin
            mode_m_q  <= mode_strap_in;
            mode_s_q  <= mode_m_q;
            strap_m_q <= sync_strap_in;
            strap_s_q <= strap_m_q;
            res_m_q   <= freq_set_resistor_in;
            res_s_q   <= res_m_q;
            en_m_q    <= en_in;
            en_s_q    <= en_m_q;
            sync_m_q  <= sync_in;
            sync_s_q  <= sync_m_q;
            sync_p_q  <= sync_s_q;
        end
    end

    logic sync_rise;
    assign sync_rise = sync_s_q & ~sync_p_q;

    // ****************************************
    // period meter
    // ****************************************
    sccs_state_type state_q, state_d;
    logic [7:0]     period;
    logic           period_valid;
    logic           ext_lost;

    sccs_edge_meter #(
        .CNT_W            (8)
    ) u_meter (
        .clk_in           (clk_in),
        .rst_b_in         (rst_b_in),
        .ce_in            (ce_in),
        .restart_in       (state_q == SCCS_ST_READY),
        .rise_in          (sync_rise),
        .period_out       (period),
        .period_valid_out (period_valid),
        .timeout_out      (ext_lost)
    );

    // ****************************************
    // control state and frequency setting
    // ****************************************
    sccs_level_type mode_q, mode_d;
    logic [5:0]     strap_n_q, strap_n_d;
    logic [5:0]     n_q, n_d;
    logic [2:0]     settle_q, settle_d;
    logic           strap_done_q, strap_done_d;

    always_comb begin
        state_d      = state_q;
        mode_d       = mode_q;
        strap_n_d    = strap_n_q;
        n_d          = n_q;
        settle_d     = settle_q;
        strap_done_d = strap_done_q;
        unique case (state_q)
            SCCS_ST_STARTUP: begin
                settle_d = settle_q + 3'h1;
                // straps are read once here and never again until reset
                if (settle_q == 3'(`SCCS_STRAP_SETTLE)) begin
                    strap_done_d = 1'b1;
                    mode_d       = sccs_level_type'(mode_s_q);
                    unique case (sccs_level_type'(strap_s_q))
                        SCCS_LVL_LOW:  strap_n_d = 6'(`SCCS_N_LOW);
                        SCCS_LVL_OPEN: strap_n_d = 6'(`SCCS_N_OPEN);
                        SCCS_LVL_HIGH: strap_n_d = 6'(`SCCS_N_HIGH);
                        SCCS_LVL_RES:  strap_n_d = res_to_n(res_s_q);
                    endcase
                    if (sccs_level_type'(mode_s_q) == SCCS_LVL_HIGH) begin
                        n_d     = 6'(`SCCS_N_OPEN);
                        state_d = SCCS_ST_DRIVE;
                    end else begin
                        state_d = SCCS_ST_READY;
                    end
                end
            end
            SCCS_ST_READY: begin
                if (en_s_q)
                    state_d = SCCS_ST_DETECT;
            end
            SCCS_ST_DETECT: begin
                if (!en_s_q)
                    state_d = SCCS_ST_READY;
                else if (period_valid)
                    state_d = SCCS_ST_LOCKED;
                else if (ext_lost) begin
                    state_d = SCCS_ST_INTERNAL;
                    if (mode_q == SCCS_LVL_OPEN)
                        n_d = strap_n_q;
                end
            end
            SCCS_ST_LOCKED: begin
                if (!en_s_q)
                    state_d = SCCS_ST_READY;
                else if (ext_lost)
                    state_d = SCCS_ST_HOLD;
            end
            SCCS_ST_HOLD, SCCS_ST_INTERNAL: begin
                if (!en_s_q)
                    state_d = SCCS_ST_READY;
            end
            SCCS_ST_DRIVE: begin
                state_d = SCCS_ST_DRIVE;
            end
            default: state_d = SCCS_ST_STARTUP;
        endcase
        // in DETECT and LOCKED a measured period sets the divider; bus writes apply only in the other states
        if (period_valid && (state_q == SCCS_ST_DETECT || state_q == SCCS_ST_LOCKED))
            n_d = period_to_n(period);
        else if (freq_wr_in && strap_done_q && state_q != SCCS_ST_LOCKED && state_q != SCCS_ST_DETECT)
            n_d = khz_to_n(freq_khz_in);
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q      <= SCCS_ST_STARTUP;
            mode_q       <= SCCS_LVL_LOW;
            strap_n_q    <= 6'(`SCCS_N_RESET);
            n_q          <= 6'(`SCCS_N_RESET);
            settle_q     <= 3'h0;
            strap_done_q <= 1'b0;
        end else if (ce_in) begin
            state_q      <= state_d;
            mode_q       <= mode_d;
            strap_n_q    <= strap_n_d;
            n_q          <= n_d;
            settle_q     <= settle_d;
            strap_done_q <= strap_done_d;
        end
    end

    // ****************************************
    // internal oscillator
    // ****************************************
    // steps of two against a wrap of 5N give exactly 8 MHz / N on average;
    // the edge jitter of one system cycle is the quantisation seen on readback
    logic [8:0] acc_q, acc_d, wrap, acc_inc;
    logic       running, osc_hi;
    logic       sw_clk_d, sync_d, sync_oe_d, lock_d, hold_d;

    always_comb begin
        wrap    = 9'(n_q) * 9'h005;
        acc_inc = acc_q + 9'h002;
        acc_d   = (acc_inc >= wrap) ? acc_inc - wrap : acc_inc;
        if (state_q == SCCS_ST_LOCKED && sync_rise)
            acc_d = 9'h000;
        osc_hi    = {acc_q, 1'b0} < {1'b0, wrap};
        running   = en_s_q && (state_q == SCCS_ST_LOCKED || state_q == SCCS_ST_HOLD ||
                               state_q == SCCS_ST_INTERNAL || state_q == SCCS_ST_DRIVE);
        sw_clk_d  = running && osc_hi;
        sync_oe_d = (state_q == SCCS_ST_DRIVE);
        sync_d    = sync_oe_d && osc_hi;
        lock_d    = (state_q == SCCS_ST_LOCKED);
        hold_d    = (state_q == SCCS_ST_HOLD);
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            acc_q        <= 9'h000;
            sw_clk_out   <= 1'b0;
            sync_out     <= 1'b0;
            sync_oe_out  <= 1'b0;
            ext_lock_out <= 1'b0;
            holdover_out <= 1'b0;
            fsw_div_out  <= 6'(`SCCS_N_RESET);
        end else if (ce_in) begin
            acc_q        <= acc_d;
            sw_clk_out   <= sw_clk_d;
            sync_out     <= sync_d;
            sync_oe_out  <= sync_oe_d;
            ext_lock_out <= lock_d;
            holdover_out <= hold_d;
            fsw_div_out  <= n_q;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_drive_oe;
        (state_q == SCCS_ST_DRIVE) && ce_in |=> sync_oe_out && !ext_lock_out;
    endproperty
    a_drive_oe: assert property (p_drive_oe) else $error("output mode not driving sync");

    property p_search_on_enable;
        (state_q == SCCS_ST_READY) && en_s_q && ce_in |=> (state_q == SCCS_ST_DETECT);
    endproperty
    a_search_on_enable: assert property (p_search_on_enable) else $error("no search after enable");

    property p_align_edge;
        (state_q == SCCS_ST_LOCKED) && sync_rise && ce_in |=> (acc_q == 9'h000);
    endproperty
    a_align_edge: assert property (p_align_edge) else $error("phase not aligned to input edge");

    property p_loss_holdover;
        (state_q == SCCS_ST_LOCKED) && ext_lost && en_s_q && ce_in |=> (state_q == SCCS_ST_HOLD) ##0 $stable(n_q);
    endproperty
    a_loss_holdover: assert property (p_loss_holdover) else $error("no holdover after clock loss");

    property p_straps_frozen;
        strap_done_q |=> $stable(mode_q) && $stable(strap_n_q) && strap_done_q;
    endproperty
    a_straps_frozen: assert property (p_straps_frozen) else $error("straps changed after start-up");

    property p_div_range;
        fsw_div_out >= 6'(`SCCS_N_MIN) && fsw_div_out <= 6'(`SCCS_N_MAX);
    endproperty
    a_div_range: assert property (p_div_range) else $error("divider out of range");

    property p_bus_nearest;
        freq_wr_in && ce_in && strap_done_q && (state_q inside {SCCS_ST_READY, SCCS_ST_INTERNAL,
            SCCS_ST_HOLD, SCCS_ST_DRIVE}) ##1 ce_in |=> fsw_div_out == khz_to_n($past(freq_khz_in, 2));
    endproperty
    a_bus_nearest: assert property (p_bus_nearest) else $error("written frequency not applied");

    property p_strap_low;
        (state_q == SCCS_ST_STARTUP) && (settle_q == 3'(`SCCS_STRAP_SETTLE)) && ce_in &&
            (mode_s_q == SCCS_LVL_OPEN) && (strap_s_q == SCCS_LVL_LOW) |=> strap_n_q == 6'(`SCCS_N_LOW);
    endproperty
    a_strap_low: assert property (p_strap_low) else $error("low strap not 200 kHz");

    c_lock:     cover property ((state_q == SCCS_ST_DETECT) ##1 (state_q == SCCS_ST_LOCKED));
    c_holdover: cover property ((state_q == SCCS_ST_LOCKED) ##1 (state_q == SCCS_ST_HOLD));
    c_internal: cover property ((state_q == SCCS_ST_DETECT) ##1 (state_q == SCCS_ST_INTERNAL));
    c_drive:    cover property (sync_oe_out && sync_out);

endmodule // sccs_top
`default_nettype wire

/* File: testbench/sccs_sync_source.sv */
// behavioural external clock source that sits on the shared sync line
`timescale 1ns/1ns
`default_nettype none
module sccs_sync_source (
    input  wire logic        run_in,
    input  wire logic [15:0] half_ns_in,
    output logic             clk_out
);
    // a stopped source leaves the line low, so a lost clock looks like a dead line
    always begin
        if (run_in) begin
            #(half_ns_in) clk_out = 1'b1;
            #(half_ns_in) clk_out = 1'b0;
        end else begin
            clk_out = 1'b0;
            #10;
        end
    end
endmodule // sccs_sync_source
`default_nettype wire

/* File: testbench/sccs_tb.sv */
// self-checking bench for the switching clock source select block
`timescale 1ns/1ns
`default_nettype none
module sccs_tb;
    import sccs_pkg::*;
    localparam int LIMIT = 20000;
    logic           clk_in = 1'b0;
    logic           rst_b_in = 1'b0;
    logic           ce = 1'b1;
    logic           en_in = 1'b0;
    sccs_level_type mode_strap = SCCS_LVL_OPEN;
    sccs_level_type sync_strap = SCCS_LVL_OPEN;
    logic [4:0]     res_pos = 5'h00;
    logic           freq_wr = 1'b0;
    logic [10:0]    freq_khz = 11'h000;
    logic           src_run = 1'b0;
    logic [15:0]    src_half = 16'h0271;
    logic           sync_wire, src_clk, sw_clk, sync_drv, sync_oe, lock, hold;
    logic [5:0]     div;
    int             miscompares = 0;
    int             n_checks = 0;
    int             cycles = 0;
    // divider for each resistor position: 8 MHz over the listed frequency
    logic [5:0] res_n [19] = '{6'h28, 6'h24, 6'h21, 6'h1e, 6'h1b, 6'h19, 6'h16, 6'h14, 6'h13, 6'h11,
                               6'h0f, 6'h0e, 6'h0d, 6'h0b, 6'h0a, 6'h09, 6'h08, 6'h07, 6'h06};

    always #25 clk_in = ~clk_in;
    // one driver on the line at a time: the device while it drives, else the source
    assign sync_wire = sync_oe ? sync_drv : src_clk;

    sccs_top u_sccs_top (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce), .en_in(en_in),
        .mode_strap_in(mode_strap), .sync_strap_in(sync_strap), .freq_set_resistor_in(res_pos),
        .sync_in(sync_wire), .freq_wr_in(freq_wr), .freq_khz_in(freq_khz), .sw_clk_out(sw_clk),
        .sync_out(sync_drv), .sync_oe_out(sync_oe), .ext_lock_out(lock), .holdover_out(hold),
        .fsw_div_out(div));
    sccs_sync_source u_sccs_sync_source (.run_in(src_run), .half_ns_in(src_half), .clk_out(src_clk));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #5;
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_val({7'h00, got}, {7'h00, exp}, what);
    endtask

    task automatic power_up(input sccs_level_type m, input sccs_level_type s, input logic [4:0] r);
        rst_b_in = 1'b0;
        en_in = 1'b0;
        src_run = 1'b0;
        mode_strap = m;
        sync_strap = s;
        res_pos = r;
        step(12);
        rst_b_in = 1'b1;
        step(10);
    endtask

    task automatic wait_lock;
        for (int i = 0; i < 300 && lock !== 1'b1; i++) step(1);
    endtask

    task automatic bus_write(input logic [10:0] khz, input logic [5:0] exp);
        freq_wr = 1'b1;
        freq_khz = khz;
        step(1);
        freq_wr = 1'b0;
        step(2);
        chk_val({2'b00, div}, {2'b00, exp}, "bus divider");
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_input_lock;
        power_up(SCCS_LVL_LOW, SCCS_LVL_OPEN, 5'h00);
        src_half = 16'h0271;
        src_run = 1'b1;
        step(20);
        en_in = 1'b1;
        wait_lock();
        chk_bit(lock, 1'b1, "lock in input mode");
        chk_val({2'b00, div}, 8'h0a, "measured divider");
        @(posedge sync_wire);
        step(8);
        chk_bit(sw_clk, 1'b1, "phase after sync rise");
        step(13);
        chk_bit(sw_clk, 1'b0, "phase mid period");
        bus_write(11'h064, 6'h0a);
        src_run = 1'b0;
        for (int i = 0; i < 300 && hold !== 1'b1; i++) step(1);
        chk_bit(hold, 1'b1, "holdover");
        chk_bit(lock, 1'b0, "lock dropped");
        chk_val({2'b00, div}, 8'h0a, "holdover divider");
        en_in = 1'b0;
        step(5);
        src_run = 1'b1;
        step(20);
        en_in = 1'b1;
        wait_lock();
        chk_bit(lock, 1'b1, "relock on new enable");
        chk_bit(hold, 1'b0, "holdover cleared");
        $display("test input_lock done");
    endtask

    task automatic test_auto_strap;
        sccs_level_type lv [3] = '{SCCS_LVL_LOW, SCCS_LVL_OPEN, SCCS_LVL_HIGH};
        logic [5:0]     ex [3] = '{6'h28, 6'h14, 6'h08};
        for (int i = 0; i < 22; i++) begin
            if (i < 3) power_up(SCCS_LVL_OPEN, lv[i], 5'h00);
            else power_up(SCCS_LVL_OPEN, SCCS_LVL_RES, 5'(i - 3));
            en_in = 1'b1;
            step(260);
            chk_val({2'b00, div}, {2'b00, (i < 3) ? ex[i] : res_n[i - 3]}, "strap divider");
            chk_bit(lock, 1'b0, "no lock without clock");
        end
        // straps changed after start-up must be ignored
        sync_strap = SCCS_LVL_LOW;
        mode_strap = SCCS_LVL_HIGH;
        res_pos = 5'h00;
        en_in = 1'b0;
        step(5);
        en_in = 1'b1;
        step(260);
        chk_val({2'b00, div}, 8'h06, "strap held");
        chk_bit(sync_oe, 1'b0, "mode held");
        $display("test auto_strap done");
    endtask

    task automatic test_auto_follow;
        power_up(SCCS_LVL_OPEN, SCCS_LVL_HIGH, 5'h00);
        src_half = 16'h04e2;
        src_run = 1'b1;
        step(20);
        en_in = 1'b1;
        wait_lock();
        chk_bit(lock, 1'b1, "auto lock");
        chk_val({2'b00, div}, 8'h14, "auto divider");
        $display("test auto_follow done");
    endtask

    task automatic test_output;
        time t0;
        power_up(SCCS_LVL_HIGH, SCCS_LVL_OPEN, 5'h00);
        en_in = 1'b1;
        step(300);
        chk_bit(sync_oe, 1'b1, "drives sync");
        chk_bit(lock, 1'b0, "no search");
        chk_val({2'b00, div}, 8'h14, "output divider");
        @(posedge sync_drv);
        t0 = $time;
        @(posedge sync_drv);
        chk_val(8'(($time - t0) / 50), 8'h32, "sync period cycles");
        step(1);
        $display("test output done");
    endtask

    task automatic test_bus;
        logic [10:0] khz [6] = '{11'h32a, 11'h064, 11'h7d0, 11'h477, 11'h1a4, 11'h19a};
        logic [5:0]  ex [6] = '{6'h0a, 6'h28, 6'h06, 6'h07, 6'h13, 6'h14};
        power_up(SCCS_LVL_LOW, SCCS_LVL_OPEN, 5'h00);
        en_in = 1'b1;
        step(260);
        chk_val({2'b00, div}, 8'h14, "default divider");
        for (int i = 0; i < 6; i++) bus_write(khz[i], ex[i]);
        // a frozen block must ignore the write, then take the same write repeated once the enable returns
        ce = 1'b0;
        bus_write(11'h0c8, 6'h14);
        ce = 1'b1;
        bus_write(11'h0c8, 6'h28);
        $display("test bus done");
    endtask

    // ****************************************
    // run control
    // ****************************************
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            $display("ERROR at %0t: run timed out", $time);
            summarize();
        end
    end

    initial begin
        test_input_lock();
        test_auto_strap();
        test_auto_follow();
        test_output();
        test_bus();
        summarize();
    end
endmodule // sccs_tb
`default_nettype wire
